/* dv/npx_sta_model.sv */
module npx_sta_model (
   input wire logic clk_i,
   input wire logic dut_mdio_i,
   input wire logic dut_oe_n_i,
   output logic mdc_o,
   output logic mdio_o
);
   timeunit 1ns;
   timeprecision 100ps;
   import npx_pkg::*;

   logic host_en = 1'b1;
   logic host_bit = 1'b1;

   initial mdc_o = 1'b0;

   // Shared line with pull-up
   assign mdio_o = host_en ? host_bit : (dut_oe_n_i ? 1'b1 : dut_mdio_i);

   task automatic bit_cyc(input logic b, output logic r);
      @(posedge clk_i);
      #1;
      mdc_o = 1'b0;
      host_bit = b;
      repeat (2) @(posedge clk_i);
      #1;
      r = mdio_o;
      mdc_o = 1'b1;
      repeat (2) @(posedge clk_i);
   endtask : bit_cyc

   task automatic xfer(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rd);
      logic [13:0] hdr;
      logic r;
      hdr = {2'b01, op, pa, ra};
      wd = wd & ((ra == NPX_REG_EXT_CTRL) ? 16'h87ED : 16'hBFFF);
      host_en = 1'b1;
      repeat (32) bit_cyc(1'b1, r);
      for (int i = 13; i >= 0; i--) bit_cyc(hdr[i], r);
      #1;
      host_en = (op == NPX_OP_WRITE);
      bit_cyc(1'b1, r);
      bit_cyc(1'b0, r);
      for (int i = 15; i >= 0; i--) begin
         bit_cyc(wd[i], r);
         rd[i] = r;
      end
      @(posedge clk_i);
      #1;
      mdc_o = 1'b0;
      host_en = 1'b1;
      host_bit = 1'b1;
      repeat (4) @(posedge clk_i);
   endtask : xfer
endmodule : npx_sta_model

/* dv/tb_top.sv */
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import npx_pkg::*;

   localparam int TMO = 20000;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic soft_rst = 1'b0;
   logic pg_vld = 1'b0;
   logic np_rst = 1'b0;
   logic base_tg = 1'b0;
   logic [4:0] strap = 5'h15;
   logic [4:0] my_pa = 5'h15;
   npx_word_t pg_word = 16'h0000;
   logic mdc, mdio, dut_mdio, dut_oe_n, ovr, scr_t, nrzi, inv, scr_d, tg_err;
   npx_phyad_t phy_addr;
   logic [15:0] rd;
   logic [15:0] outs;
   int err_total = 0;
   int cmp_count = 0;
   int cyc = 0;

   assign outs = {10'h000, tg_err, ovr, scr_t, nrzi, inv, scr_d};
   always #2 clk = ~clk;

   npx_regs u_dut (
      .clk_i(clk), .rst_n_i(rst_n), .soft_rst_i(soft_rst), .mdc_i(mdc), .mdio_i(mdio),
      .mdio_o(dut_mdio), .mdio_oe_n_o(dut_oe_n), .addr_strap_4_i(strap[4]),
      .addr_strap_3_i(strap[3]), .addr_strap_2_i(strap[2]), .addr_strap_1_i(strap[1]),
      .addr_strap_0_i(strap[0]), .page_valid_i(pg_vld), .page_word_i(pg_word),
      .np_restart_i(np_rst), .base_toggle_i(base_tg), .override_en_o(ovr),
      .scr_test_o(scr_t), .nrzi_sel_o(nrzi), .inv_code_test_o(inv), .scr_disable_o(scr_d),
      .phy_addr_o(phy_addr), .page_toggle_err_o(tg_err)
   );

   npx_sta_model u_sta (
      .clk_i(clk), .dut_mdio_i(dut_mdio), .dut_oe_n_i(dut_oe_n), .mdc_o(mdc), .mdio_o(mdio)
   );

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic rd_reg(input logic [4:0] ra, output logic [15:0] d);
      u_sta.xfer(NPX_OP_READ, my_pa, ra, 16'h0000, d);
   endtask : rd_reg

   task automatic wr(input logic [4:0] ra, input logic [15:0] d);
      logic [15:0] dummy;
      u_sta.xfer(NPX_OP_WRITE, my_pa, ra, d, dummy);
   endtask : wr

   task automatic page(input logic [15:0] w);
      @(posedge clk);
      #1;
      pg_vld = 1'b1;
      pg_word = w;
      @(posedge clk);
      #1;
      pg_vld = 1'b0;
      @(posedge clk);
   endtask : page

   task automatic restart(input logic b);
      @(posedge clk);
      #1;
      np_rst = 1'b1;
      base_tg = b;
      @(posedge clk);
      #1;
      np_rst = 1'b0;
   endtask : restart

   task automatic t_reset;
      rd_reg(NPX_REG_PARTNER_NP, rd);
      chk(rd, 16'h0000);
      rd_reg(NPX_REG_EXT_CTRL, rd);
      chk(rd, {5'h00, 5'h15, 6'h08});
      chk({11'h000, phy_addr}, 16'h0015);
      chk(outs, 16'h0004);
   endtask : t_reset

   task automatic t_pages;
      restart(1'b0);
      page(16'h0000);
      chk(outs, 16'h0024);
      restart(1'b1);
      page(16'hF5A5);
      chk(outs, 16'h0004);
      rd_reg(NPX_REG_PARTNER_NP, rd);
      chk(rd, 16'hB5A5);
      page(16'h0ABC);
      chk(outs, 16'h0004);
      page(16'h0ABC);
      chk(outs, 16'h0024);
      wr(NPX_REG_PARTNER_NP, 16'h1234);
      rd_reg(NPX_REG_PARTNER_NP, rd);
      chk(rd, 16'h0ABC);
      restart(1'b1);
   endtask : t_pages

   task automatic t_ext;
      wr(NPX_REG_EXT_CTRL, 16'h07E5);
      chk(outs, 16'h000B);
      rd_reg(NPX_REG_EXT_CTRL, rd);
      chk(rd, {5'h00, 5'h15, 6'h25});
      wr(NPX_REG_EXT_CTRL, 16'h8008);
      chk(outs, 16'h0014);
      wr(NPX_REG_PARTNER_NP, 16'h0000);
      chk(outs, 16'h0004);
      u_sta.xfer(NPX_OP_READ, 5'h0A, NPX_REG_EXT_CTRL, 16'h0000, rd);
      chk(rd, 16'hFFFF);
      u_sta.xfer(NPX_OP_WRITE, 5'h0A, NPX_REG_EXT_CTRL, 16'h0001, rd);
      chk(outs, 16'h0004);
   endtask : t_ext

   task automatic t_resets;
      wr(NPX_REG_EXT_CTRL, 16'h0025);
      chk(outs, 16'h000B);
      strap = 5'h0A;
      @(posedge clk);
      #1;
      soft_rst = 1'b1;
      @(posedge clk);
      #1;
      soft_rst = 1'b0;
      @(posedge clk);
      chk(outs, 16'h0004);
      chk({11'h000, phy_addr}, 16'h0015);
      #1;
      rst_n = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      rst_n = 1'b1;
      repeat (3) @(posedge clk);
      chk({11'h000, phy_addr}, 16'h000A);
      my_pa = 5'h0A;
      rd_reg(NPX_REG_EXT_CTRL, rd);
      chk(rd, {5'h00, 5'h0A, 6'h08});
   endtask : t_resets

   task automatic report_and_stop;
      $display("checks %0d errors %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : report_and_stop

   always @(posedge clk) begin
      cyc++;
      if (cyc == TMO) begin
         err_total++;
         report_and_stop();
      end
   end

   initial begin
      repeat (12) @(posedge clk);
      #1;
      rst_n = 1'b1;
      repeat (3) @(posedge clk);
      t_reset();
      t_pages();
      t_ext();
      t_resets();
      report_and_stop();
   end
endmodule : tb_top

/* pkg/npx_pkg.sv */
package npx_pkg;
   typedef logic [15:0] npx_word_t;
   typedef logic [4:0] npx_phyad_t;

   localparam logic [4:0] NPX_REG_PARTNER_NP = 5'h08;
   localparam logic [4:0] NPX_REG_EXT_CTRL = 5'h10;

   localparam int NPX_NP_MORE_BIT = 15;
   localparam int NPX_NP_RSV_BIT = 14;
   localparam int NPX_NP_FORMAT_BIT = 13;
   localparam int NPX_NP_COMPLY_BIT = 12;
   localparam int NPX_NP_TOGGLE_BIT = 11;
   localparam npx_word_t NPX_NP_RESET = 16'h0000;
   localparam npx_word_t NPX_NP_RO_MASK = 16'hBFFF;

   localparam int NPX_EXT_OVR_BIT = 15;
   localparam int NPX_EXT_ADDR_LSB = 6;
   localparam int NPX_EXT_SCR_TEST_BIT = 5;
   localparam int NPX_EXT_NRZI_BIT = 3;
   localparam int NPX_EXT_INV_CODE_BIT = 2;
   localparam int NPX_EXT_SCR_DIS_BIT = 0;
   localparam npx_word_t NPX_EXT_RESET = 16'h0008;
   localparam npx_word_t NPX_EXT_RW_MASK = 16'hF83F;

   localparam logic [5:0] NPX_PRE_LEN = 6'h20;
   localparam logic [1:0] NPX_OP_READ = 2'h2;
   localparam logic [1:0] NPX_OP_WRITE = 2'h1;
   localparam logic [5:0] NPX_OP_LAST = 6'h01;
   localparam logic [5:0] NPX_ADDR_LAST = 6'h09;
   localparam logic [5:0] NPX_TA_LAST = 6'h01;
   localparam logic [5:0] NPX_DATA_LAST = 6'h0F;

   typedef enum logic [2:0] {
      NPX_ST_PRE = 3'b000,
      NPX_ST_START = 3'b001,
      NPX_ST_OP = 3'b010,
      NPX_ST_ADDR = 3'b011,
      NPX_ST_TA = 3'b100,
      NPX_ST_DATA = 3'b101
   } npx_state_t;
endpackage : npx_pkg

/* rtl/npx_page_capture.sv */
module npx_page_capture (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic page_valid_i,
   input npx_pkg::npx_word_t page_word_i,
   input wire logic np_restart_i,
   input wire logic base_toggle_i,
   output npx_pkg::npx_word_t np_word_o,
   output logic toggle_err_o
);
   import npx_pkg::*;

   logic exp_toggle;

   // load received word, reserved bit dropped
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         np_word_o <= NPX_NP_RESET;
      end else if (page_valid_i) begin
         np_word_o <= page_word_i & NPX_NP_RO_MASK;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         exp_toggle <= 1'b0;
         toggle_err_o <= 1'b0;
      end else if (np_restart_i) begin
         // Same-cycle page is the first one: judge it against the base word
         exp_toggle <= page_valid_i ? base_toggle_i : ~base_toggle_i;
         toggle_err_o <= page_valid_i && page_word_i[NPX_NP_TOGGLE_BIT] == base_toggle_i;
      end else if (page_valid_i) begin
         exp_toggle <= ~exp_toggle;
         toggle_err_o <= page_word_i[NPX_NP_TOGGLE_BIT] != exp_toggle;
      end
   end

   property p_rsv_zero;
      @(posedge clk_i) disable iff (!rst_n_i)
      !np_word_o[NPX_NP_RSV_BIT];
   endproperty
   a_rsv_zero: assert property (p_rsv_zero) else $error("Reserved partner bit set");

   property p_load;
      @(posedge clk_i) disable iff (!rst_n_i)
      page_valid_i |=> np_word_o[13:0] == $past(page_word_i[13:0])
         && np_word_o[NPX_NP_MORE_BIT] == $past(page_word_i[NPX_NP_MORE_BIT]);
   endproperty
   a_load: assert property (p_load) else $error("Partner word not loaded");

   property p_first_toggle;
      @(posedge clk_i) disable iff (!rst_n_i)
      np_restart_i ##1 (!np_restart_i && !page_valid_i) ##1 (!np_restart_i && page_valid_i)
         |=> toggle_err_o ==
         ($past(page_word_i[NPX_NP_TOGGLE_BIT]) == $past(base_toggle_i, 3));
   endproperty
   a_first_toggle: assert property (p_first_toggle) else $error("First toggle check wrong");

   property p_toggle_flip;
      @(posedge clk_i) disable iff (!rst_n_i)
      page_valid_i && !np_restart_i |=> exp_toggle != $past(exp_toggle);
   endproperty
   a_toggle_flip: assert property (p_toggle_flip) else $error("Toggle did not invert");
endmodule : npx_page_capture

/* rtl/npx_regs.sv */
module npx_regs (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic soft_rst_i,
   input wire logic mdc_i,
   input wire logic mdio_i,
   output logic mdio_o,
   output logic mdio_oe_n_o,
   input wire logic addr_strap_4_i,
   input wire logic addr_strap_3_i,
   input wire logic addr_strap_2_i,
   input wire logic addr_strap_1_i,
   input wire logic addr_strap_0_i,
   input wire logic page_valid_i,
   input npx_pkg::npx_word_t page_word_i,
   input wire logic np_restart_i,
   input wire logic base_toggle_i,
   output logic override_en_o,
   output logic scr_test_o,
   output logic nrzi_sel_o,
   output logic inv_code_test_o,
   output logic scr_disable_o,
   output npx_pkg::npx_phyad_t phy_addr_o,
   output logic page_toggle_err_o
);
   import npx_pkg::*;

   logic mdc_prev;
   logic mdc_rise;
   npx_state_t state;
   logic [5:0] bit_cnt;
   logic [1:0] op;
   logic [9:0] addr_sh;
   npx_word_t data_sh;
   npx_word_t rd_sh;
   npx_word_t rd_word;
   logic hit;
   logic wr_pulse;
   logic [4:0] wr_reg;
   npx_word_t wr_data;
   npx_word_t ext_ctrl;
   npx_word_t np_word;
   npx_phyad_t strap_addr;

   npx_strap_latch u_strap (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .addr_strap_4_i(addr_strap_4_i),
      .addr_strap_3_i(addr_strap_3_i),
      .addr_strap_2_i(addr_strap_2_i),
      .addr_strap_1_i(addr_strap_1_i),
      .addr_strap_0_i(addr_strap_0_i),
      .phy_addr_o(strap_addr)
   );

   npx_page_capture u_page (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .page_valid_i(page_valid_i),
      .page_word_i(page_word_i),
      .np_restart_i(np_restart_i),
      .base_toggle_i(base_toggle_i),
      .np_word_o(np_word),
      .toggle_err_o(page_toggle_err_o)
   );

   assign phy_addr_o = strap_addr;
   assign mdc_rise = mdc_i & ~mdc_prev;
   assign hit = addr_sh[9:5] == strap_addr;

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         mdc_prev <= 1'b0;
      end else begin
         mdc_prev <= mdc_i;
      end
   end

   // Management frame sequencer, one step per MDC rise
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         state <= NPX_ST_PRE;
         bit_cnt <= 6'h00;
         op <= 2'h0;
         addr_sh <= 10'h000;
         data_sh <= 16'h0000;
      end else if (mdc_rise) begin
         case (state)
            NPX_ST_PRE: begin
               if (mdio_i) begin
                  if (bit_cnt != NPX_PRE_LEN) begin
                     bit_cnt <= bit_cnt + 6'h01;
                  end
               end else if (bit_cnt == NPX_PRE_LEN) begin
                  state <= NPX_ST_START;
                  bit_cnt <= 6'h00;
               end else begin
                  bit_cnt <= 6'h00;
               end
            end
            NPX_ST_START: begin
               state <= mdio_i ? NPX_ST_OP : NPX_ST_PRE;
            end
            NPX_ST_OP: begin
               op <= {op[0], mdio_i};
               if (bit_cnt == NPX_OP_LAST) begin
                  state <= NPX_ST_ADDR;
                  bit_cnt <= 6'h00;
               end else begin
                  bit_cnt <= bit_cnt + 6'h01;
               end
            end
            NPX_ST_ADDR: begin
               addr_sh <= {addr_sh[8:0], mdio_i};
               if (bit_cnt == NPX_ADDR_LAST) begin
                  state <= NPX_ST_TA;
                  bit_cnt <= 6'h00;
               end else begin
                  bit_cnt <= bit_cnt + 6'h01;
               end
            end
            NPX_ST_TA: begin
               if (bit_cnt == NPX_TA_LAST) begin
                  state <= NPX_ST_DATA;
                  bit_cnt <= 6'h00;
               end else begin
                  bit_cnt <= bit_cnt + 6'h01;
               end
            end
            NPX_ST_DATA: begin
               data_sh <= {data_sh[14:0], mdio_i};
               if (bit_cnt == NPX_DATA_LAST) begin
                  state <= NPX_ST_PRE;
                  bit_cnt <= 6'h00;
               end else begin
                  bit_cnt <= bit_cnt + 6'h01;
               end
            end
            default: begin
               state <= NPX_ST_PRE;
               bit_cnt <= 6'h00;
            end
         endcase
      end
   end

   // Write strobe after last data bit of a frame for this address
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         wr_pulse <= 1'b0;
         wr_reg <= 5'h00;
         wr_data <= 16'h0000;
      end else begin
         wr_pulse <= mdc_rise && state == NPX_ST_DATA && bit_cnt == NPX_DATA_LAST
                     && op == NPX_OP_WRITE && hit;
         wr_reg <= addr_sh[4:0];
         wr_data <= {data_sh[14:0], mdio_i};
      end
   end

   // Read mux; unmapped addresses answer zero
   always_comb begin
      rd_word = 16'h0000;
      if (addr_sh[4:0] == NPX_REG_PARTNER_NP) begin
         rd_word = np_word;
      end else if (addr_sh[4:0] == NPX_REG_EXT_CTRL) begin
         rd_word = ext_ctrl;
         rd_word[NPX_EXT_ADDR_LSB +: 5] = strap_addr;
      end
   end

   // Read data driver, changes only on the clock rise that follows an MDC rise
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         mdio_o <= 1'b0;
         mdio_oe_n_o <= 1'b1;
         rd_sh <= 16'h0000;
      end else if (mdc_rise) begin
         if (state == NPX_ST_TA && bit_cnt == 6'h00 && op == NPX_OP_READ && hit) begin
            mdio_o <= 1'b0;
            mdio_oe_n_o <= 1'b0;
         end else if (state == NPX_ST_TA && bit_cnt == NPX_TA_LAST && !mdio_oe_n_o) begin
            mdio_o <= rd_word[15];
            rd_sh <= {rd_word[14:0], 1'b0};
         end else if (state == NPX_ST_DATA && !mdio_oe_n_o) begin
            if (bit_cnt == NPX_DATA_LAST) begin
               mdio_o <= 1'b0;
               mdio_oe_n_o <= 1'b1;
            end else begin
               mdio_o <= rd_sh[15];
               rd_sh <= {rd_sh[14:0], 1'b0};
            end
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i || soft_rst_i) begin
         ext_ctrl <= NPX_EXT_RESET;
      end else if (wr_pulse && wr_reg == NPX_REG_EXT_CTRL) begin
         ext_ctrl <= wr_data & NPX_EXT_RW_MASK;
      end else if (wr_pulse) begin
         ext_ctrl[NPX_EXT_OVR_BIT] <= 1'b0;
      end
   end

   assign override_en_o = ext_ctrl[NPX_EXT_OVR_BIT];
   assign scr_test_o = ext_ctrl[NPX_EXT_SCR_TEST_BIT];
   assign nrzi_sel_o = ext_ctrl[NPX_EXT_NRZI_BIT];
   assign inv_code_test_o = ext_ctrl[NPX_EXT_INV_CODE_BIT];
   assign scr_disable_o = ext_ctrl[NPX_EXT_SCR_DIS_BIT];

   property p_ovr_clear;
      @(posedge clk_i) disable iff (!rst_n_i)
      wr_pulse && !soft_rst_i && !(wr_reg == NPX_REG_EXT_CTRL && wr_data[NPX_EXT_OVR_BIT])
         |=> !override_en_o;
   endproperty
   a_ovr_clear: assert property (p_ovr_clear) else $error("Override enable not cleared");

   property p_ovr_hold;
      @(posedge clk_i) disable iff (!rst_n_i)
      !wr_pulse && !soft_rst_i |=> $stable(override_en_o);
   endproperty
   a_ovr_hold: assert property (p_ovr_hold) else $error("Override enable moved unprompted");

   property p_np_ro;
      @(posedge clk_i) disable iff (!rst_n_i)
      wr_pulse && wr_reg == NPX_REG_PARTNER_NP && !page_valid_i |=> $stable(np_word);
   endproperty
   a_np_ro: assert property (p_np_ro) else $error("Partner word changed by write");

   property p_ctrl_write;
      @(posedge clk_i) disable iff (!rst_n_i)
      wr_pulse && wr_reg == NPX_REG_EXT_CTRL && !soft_rst_i |=>
         scr_test_o == $past(wr_data[NPX_EXT_SCR_TEST_BIT])
         && nrzi_sel_o == $past(wr_data[NPX_EXT_NRZI_BIT])
         && inv_code_test_o == $past(wr_data[NPX_EXT_INV_CODE_BIT])
         && scr_disable_o == $past(wr_data[NPX_EXT_SCR_DIS_BIT]);
   endproperty
   a_ctrl_write: assert property (p_ctrl_write) else $error("Control bits not written");

   property p_soft_rst;
      @(posedge clk_i) disable iff (!rst_n_i)
      soft_rst_i |=> !scr_test_o && nrzi_sel_o && !inv_code_test_o && !scr_disable_o
         && !override_en_o && phy_addr_o == $past(phy_addr_o);
   endproperty
   a_soft_rst: assert property (p_soft_rst) else $error("Soft reset values wrong");

   property p_no_drive_idle;
      @(posedge clk_i) disable iff (!rst_n_i)
      state == NPX_ST_PRE || state == NPX_ST_START || state == NPX_ST_OP |-> mdio_oe_n_o;
   endproperty
   a_no_drive_idle: assert property (p_no_drive_idle) else $error("Data pin driven outside read");

   // Data pin protocol checks
   property p_oe_start;
      @(posedge clk_i) disable iff (!rst_n_i)
      $fell(mdio_oe_n_o) |-> $past(op) == NPX_OP_READ && $past(hit) && $past(state) == NPX_ST_TA;
   endproperty
   a_oe_start: assert property (p_oe_start) else $error("Data pin driven without hit");

   property p_oe_release;
      @(posedge clk_i) disable iff (!rst_n_i)
      mdc_rise && state == NPX_ST_DATA && bit_cnt == NPX_DATA_LAST |=> mdio_oe_n_o;
   endproperty
   a_oe_release: assert property (p_oe_release) else $error("Data pin not released");

   property p_ta_low;
      @(posedge clk_i) disable iff (!rst_n_i)
      state == NPX_ST_TA && !mdio_oe_n_o |-> !mdio_o;
   endproperty
   a_ta_low: assert property (p_ta_low) else $error("Turnaround bit not low");

   property p_read_rsv;
      @(posedge clk_i) disable iff (!rst_n_i)
      state == NPX_ST_TA && addr_sh[4:0] == NPX_REG_PARTNER_NP |-> !rd_word[NPX_NP_RSV_BIT];
   endproperty
   a_read_rsv: assert property (p_read_rsv) else $error("Reserved bit read as one");

   // Reset and storage checks
   property p_ext_reset;
      @(posedge clk_i)
      !rst_n_i |=> !override_en_o && !scr_test_o && nrzi_sel_o && !inv_code_test_o
         && !scr_disable_o;
   endproperty
   a_ext_reset: assert property (p_ext_reset) else $error("Control reset values wrong");

   property p_np_reset;
      @(posedge clk_i)
      !rst_n_i |=> np_word == NPX_NP_RESET;
   endproperty
   a_np_reset: assert property (p_np_reset) else $error("Partner word not reset");

   property p_ovr_set;
      @(posedge clk_i) disable iff (!rst_n_i)
      wr_pulse && wr_reg == NPX_REG_EXT_CTRL && wr_data[NPX_EXT_OVR_BIT] && !soft_rst_i
         |=> override_en_o;
   endproperty
   a_ovr_set: assert property (p_ovr_set) else $error("Override enable not set");

   property p_rsv_store;
      @(posedge clk_i) disable iff (!rst_n_i)
      wr_pulse && wr_reg == NPX_REG_EXT_CTRL && !soft_rst_i |=>
         ((ext_ctrl ^ $past(wr_data)) & NPX_EXT_RW_MASK) == 16'h0000;
   endproperty
   a_rsv_store: assert property (p_rsv_store) else $error("Control bits not stored");
endmodule : npx_regs

/* rtl/npx_strap_latch.sv */
module npx_strap_latch (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic addr_strap_4_i,
   input wire logic addr_strap_3_i,
   input wire logic addr_strap_2_i,
   input wire logic addr_strap_1_i,
   input wire logic addr_strap_0_i,
   output npx_pkg::npx_phyad_t phy_addr_o
);
   import npx_pkg::*;

   logic load_pending;

   // capture straps once after hardware reset
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         load_pending <= 1'b1;
         phy_addr_o <= 5'h00;
      end else if (load_pending) begin
         load_pending <= 1'b0;
         phy_addr_o <= {addr_strap_4_i, addr_strap_3_i, addr_strap_2_i,
                        addr_strap_1_i, addr_strap_0_i};
      end
   end

   property p_addr_hold;
      @(posedge clk_i) disable iff (!rst_n_i)
      !load_pending |=> $stable(phy_addr_o);
   endproperty
   a_addr_hold: assert property (p_addr_hold) else $error("PHY address moved after load");

   property p_addr_load;
      @(posedge clk_i) disable iff (!rst_n_i)
      load_pending |=> phy_addr_o == {$past(addr_strap_4_i), $past(addr_strap_3_i),
         $past(addr_strap_2_i), $past(addr_strap_1_i), $past(addr_strap_0_i)};
   endproperty
   a_addr_load: assert property (p_addr_load) else $error("PHY address not from straps");
endmodule : npx_strap_latch
